/* smt_pkg.sv */
package smt_pkg;

  // register byte addresses on the apb bus
  localparam logic [11:0] SMT_MODE_ADDR = 12'h000;
  localparam logic [11:0] SMT_LOW_ADDR = 12'h004;
  localparam logic [11:0] SMT_HIGH_ADDR = 12'h008;
  localparam logic [11:0] SMT_STAT_ADDR = 12'h00c;

  // mode register field positions
  localparam int SMT_WLO_BIT = 0;
  localparam int SMT_PSC_LO_BIT = 1;
  localparam int SMT_SRC_BIT = 3;
  localparam int SMT_MODE_LO_BIT = 4;
  localparam int SMT_POL_BIT = 6;
  localparam int SMT_HALT_BIT = 7;

  // status register field positions
  localparam int SMT_TFLAG_BIT = 0;
  localparam int SMT_PFLAG_BIT = 1;

  // reset values
  localparam logic [7:0] SMT_MODE_RST = 8'h00;
  localparam logic [15:0] SMT_COUNT_RST = 16'h0000;
  localparam logic [15:0] SMT_RELOAD_RST = 16'h0000;

  // operating mode codes
  localparam logic [1:0] SMT_OP_TIMER = 2'h0;
  localparam logic [1:0] SMT_OP_PULSE = 2'h1;
  localparam logic [1:0] SMT_OP_EVENT = 2'h2;
  localparam logic [1:0] SMT_OP_WIDTH = 2'h3;

  // prescaler masks: tick when masked bits are all ones
  localparam logic [5:0] SMT_DIV8_MASK = 6'h07;
  localparam logic [5:0] SMT_DIV16_MASK = 6'h0f;
  localparam logic [5:0] SMT_DIV32_MASK = 6'h1f;
  localparam logic [5:0] SMT_DIV64_MASK = 6'h3f;

  // apb request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } smt_apb_req_s;

  // apb answer bundle
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } smt_apb_rsp_s;

  // counter pin as two signals
  typedef struct packed {
    logic pin_out;
    logic pin_oe_n;
  } smt_pin_drv_s;

  // whole state of the timer
  typedef struct packed {
    logic [7:0] mode;
    logic [15:0] count;
    logic [15:0] reload;
    logic [7:0] lo_hold;
    logic [7:0] snap_lo;
    logic [5:0] psc;
    logic [1:0] pin_sync;
    logic pin_prev;
    logic [1:0] scs_sync;
    logic scs_prev;
    logic pin_out;
    logic tmr_flag;
    logic pin_flag;
    logic [31:0] rdata;
    logic slverr;
  } smt_state_s;

endpackage

/* smt_timer.sv */
// The APB register port and the address map were decided locally.
module smt_timer #(
  parameter int PSC_W = 6
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire smt_pkg::smt_apb_req_s apb_req,
  output smt_pkg::smt_apb_rsp_s apb_rsp,
  // counter pin, special source
  input wire logic counter_pin_in,
  output smt_pkg::smt_pin_drv_s counter_pin,
  input wire logic special_count_source,
  // request flags
  output logic timer_irq,
  output logic pin_irq
);
  import smt_pkg::*;

  // prescaler must reach divide by 64
  initial begin
    if (PSC_W != 6) begin
      $error("smt_timer: PSC_W must be 6");
    end
  end

  smt_state_s st; // registered state
  smt_state_s next_st; // next state

  logic setup; // apb setup cycle
  logic access; // apb access cycle
  logic wr_en; // write takes effect
  logic rd_setup; // read captured this cycle
  logic hi_wr; // high byte write
  logic lo_rd; // low byte read setup
  logic hi_rd; // high byte read setup
  logic mapped; // address decodes
  logic psc_tick; // prescaled pulse
  logic scs_edge; // special source rising edge
  logic pin_lvl; // synchronised pin level
  logic pin_rise; // pin rising edge
  logic pin_fall; // pin falling edge
  logic src_pulse; // internal source pulse
  logic tick; // count pulse to counter
  logic uflow; // underflow event
  logic pol; // polarity select
  logic [1:0] op; // operating mode
  logic [15:0] wr_value; // reload value being written

  // bus phase decode
  always_comb begin
    setup = apb_req.psel & ~apb_req.penable;
    access = apb_req.psel & apb_req.penable;
    wr_en = access & apb_req.pwrite;
    rd_setup = setup & ~apb_req.pwrite;
    mapped = (apb_req.paddr == SMT_MODE_ADDR) | (apb_req.paddr == SMT_LOW_ADDR) |
             (apb_req.paddr == SMT_HIGH_ADDR) | (apb_req.paddr == SMT_STAT_ADDR);
    hi_wr = wr_en & (apb_req.paddr == SMT_HIGH_ADDR);
    lo_rd = rd_setup & (apb_req.paddr == SMT_LOW_ADDR);
    hi_rd = rd_setup & (apb_req.paddr == SMT_HIGH_ADDR);
    wr_value = {apb_req.pwdata[7:0], st.lo_hold};
  end

  // count pulse selection
  always_comb begin
    pol = st.mode[SMT_POL_BIT];
    op = st.mode[SMT_MODE_LO_BIT +: 2];
    // divide ratio from prescaler bits
    case (st.mode[SMT_PSC_LO_BIT +: 2])
      2'h0: psc_tick = (st.psc & SMT_DIV8_MASK) == SMT_DIV8_MASK;
      2'h1: psc_tick = (st.psc & SMT_DIV16_MASK) == SMT_DIV16_MASK;
      2'h2: psc_tick = (st.psc & SMT_DIV32_MASK) == SMT_DIV32_MASK;
      default: psc_tick = (st.psc & SMT_DIV64_MASK) == SMT_DIV64_MASK;
    endcase
    // edges only from the second synchroniser stage onward
    scs_edge = st.scs_sync[1] & ~st.scs_prev;
    pin_lvl = st.pin_sync[1];
    pin_rise = pin_lvl & ~st.pin_prev;
    pin_fall = ~pin_lvl & st.pin_prev;
    // prescaler or special source
    src_pulse = st.mode[SMT_SRC_BIT] ? scs_edge : psc_tick;
    case (op)
      // pin edges replace the internal source
      SMT_OP_EVENT: tick = pol ? pin_fall : pin_rise;
      // gate by the measured level
      SMT_OP_WIDTH: tick = src_pulse & (pin_lvl == ~pol);
      default: tick = src_pulse;
    endcase
    // halt stops all modes
    if (st.mode[SMT_HALT_BIT]) begin
      tick = 1'b0;
    end
    uflow = tick & (st.count == 16'h0000);
  end

  // next state
  always_comb begin
    next_st = st;
    // free running prescaler
    next_st.psc = st.psc + 6'h01;
    // two flop synchronisers then edge history
    next_st.pin_sync = {st.pin_sync[0], counter_pin_in};
    next_st.pin_prev = st.pin_sync[1];
    next_st.scs_sync = {st.scs_sync[0], special_count_source};
    next_st.scs_prev = st.scs_sync[1];
    // down counter with reload on underflow
    if (uflow) begin
      next_st.count = st.reload;
    end else if (tick) begin
      next_st.count = st.count - 16'h0001;
    end
    // pulse output toggles, else parks at its start level
    if (op == SMT_OP_PULSE) begin
      if (uflow) begin
        next_st.pin_out = ~st.pin_out;
      end
    end else begin
      next_st.pin_out = ~pol;
    end
    // register writes
    if (wr_en) begin
      case (apb_req.paddr)
        SMT_MODE_ADDR: begin
          next_st.mode = apb_req.pwdata[7:0];
          // a mode write parks the pin at the new start level
          next_st.pin_out = ~apb_req.pwdata[SMT_POL_BIT];
        end
        SMT_LOW_ADDR: begin
          next_st.lo_hold = apb_req.pwdata[7:0];
        end
        SMT_HIGH_ADDR: begin
          next_st.reload = wr_value;
          if (!st.mode[SMT_WLO_BIT]) begin
            next_st.count = wr_value;
          end
        end
        default: begin
        end
      endcase
    end
    // sticky flags: set wins over write-one clear
    if (wr_en && apb_req.paddr == SMT_STAT_ADDR) begin
      if (apb_req.pwdata[SMT_TFLAG_BIT]) begin
        next_st.tmr_flag = 1'b0;
      end
      if (apb_req.pwdata[SMT_PFLAG_BIT]) begin
        next_st.pin_flag = 1'b0;
      end
    end
    if (uflow) begin
      next_st.tmr_flag = 1'b1;
    end
    if (pol ? pin_rise : pin_fall) begin
      next_st.pin_flag = 1'b1;
    end
    // read data captured in setup; high read snapshots low
    if (hi_rd) begin
      next_st.snap_lo = st.count[7:0];
    end
    if (rd_setup) begin
      case (apb_req.paddr)
        SMT_MODE_ADDR: next_st.rdata = {24'h000000, st.mode};
        SMT_LOW_ADDR: next_st.rdata = {24'h000000, st.snap_lo};
        SMT_HIGH_ADDR: next_st.rdata = {24'h000000, st.count[15:8]};
        SMT_STAT_ADDR: next_st.rdata = {30'h00000000, st.pin_flag, st.tmr_flag};
        default: next_st.rdata = 32'h00000000;
      endcase
    end
    if (setup) begin
      next_st.slverr = ~mapped;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.mode <= SMT_MODE_RST;
      st.count <= SMT_COUNT_RST;
      st.reload <= SMT_RELOAD_RST;
      st.pin_out <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  always_comb begin
    apb_rsp.pready = access; // zero wait states
    apb_rsp.pslverr = access & st.slverr;
    apb_rsp.prdata = st.rdata;
    counter_pin.pin_out = st.pin_out;
    counter_pin.pin_oe_n = (op != SMT_OP_PULSE); // drives only in pulse mode
    timer_irq = st.tmr_flag;
    pin_irq = st.pin_flag;
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_uflow_reload: assert property (uflow && !hi_wr |=> st.count == $past(st.reload))
    else $error("counter did not reload on underflow");
  a_dec_step: assert property (tick && !uflow && !hi_wr |=> st.count == $past(st.count) - 16'h0001)
    else $error("counter did not decrement");
  a_uflow_flag: assert property (uflow |=> st.tmr_flag && timer_irq)
    else $error("underflow did not set flag");
  a_hi_latch: assert property (hi_wr |=> st.reload == $past(wr_value))
    else $error("reload latch not loaded");
  a_direct_load: assert property (hi_wr && !st.mode[SMT_WLO_BIT] |=> st.count == st.reload)
    else $error("counter not loaded by write");
  a_latch_only: assert property (hi_wr && st.mode[SMT_WLO_BIT] && !tick |=> st.count == $past(st.count))
    else $error("latch-only write touched counter");
  // low read returns the held snapshot, not the live count
  a_snap_read: assert property (lo_rd |=> apb_rsp.prdata[7:0] == $past(st.snap_lo))
    else $error("low read not from snapshot");
  // high read takes the snapshot of the low byte
  a_snap_take: assert property (hi_rd |=> st.snap_lo == $past(st.count[7:0]))
    else $error("snapshot not taken on high read");
  // prescaler advances on every clock
  a_psc_step: assert property (1'b1 |=> st.psc == $past(st.psc) + 6'h01)
    else $error("prescaler did not advance");
  // event mode ignores the internal source
  a_event_src: assert property (op == SMT_OP_EVENT && !(pol ? pin_fall : pin_rise) |-> !tick)
    else $error("event mode counted without pin edge");
  // width mode does not count at the inactive level
  a_width_gate: assert property (op == SMT_OP_WIDTH && pin_lvl == pol |-> !tick)
    else $error("width mode counted at inactive level");
  // special source drives the count in timer mode when selected
  a_src_sel: assert property (op == SMT_OP_TIMER && st.mode[SMT_SRC_BIT] && !st.mode[SMT_HALT_BIT] |-> tick == scs_edge)
    else $error("special source not followed");
  // pin driven in pulse output mode
  a_oe_pulse: assert property (op == SMT_OP_PULSE |-> !counter_pin.pin_oe_n)
    else $error("pin not driven in pulse mode");
  // outside pulse mode the pin rests at its start level
  a_park_level: assert property (op != SMT_OP_PULSE && !wr_en |=> st.pin_out == ~$past(pol))
    else $error("pin not parked at start level");
  // a mode write sets the start level
  a_start_level: assert property (wr_en && apb_req.paddr == SMT_MODE_ADDR |=> st.pin_out == ~$past(apb_req.pwdata[SMT_POL_BIT]))
    else $error("start level not set by mode write");
  // pin level reaches the second stage after two clocks
  a_pin_sync: assert property (counter_pin_in |-> ##2 st.pin_sync[1])
    else $error("pin synchroniser delay wrong");
  // one count per detected pin edge
  a_single_edge: assert property (op == SMT_OP_EVENT && tick |=> !tick)
    else $error("pin edge counted twice");
  // underflow flag stays set until cleared
  a_flag_sticky: assert property (timer_irq && !(wr_en && apb_req.paddr == SMT_STAT_ADDR && apb_req.pwdata[SMT_TFLAG_BIT]) |=> timer_irq)
    else $error("underflow flag dropped");
  a_halt_hold: assert property (st.mode[SMT_HALT_BIT] && !hi_wr |=> st.count == $past(st.count))
    else $error("halted counter moved");
  a_pulse_toggle: assert property (op == SMT_OP_PULSE && uflow && !wr_en |=> counter_pin.pin_out != $past(st.pin_out))
    else $error("pin did not toggle");
  a_pin_edge: assert property ((pol ? pin_rise : pin_fall) |=> pin_irq)
    else $error("pin edge did not raise request");
  a_psc_rate: assert property (!st.mode[SMT_SRC_BIT] && op == SMT_OP_TIMER && tick |=> !tick[*7])
    else $error("prescaled pulses too close");

  c_underflow: cover property (uflow);
  c_pulse_toggle: cover property (op == SMT_OP_PULSE && uflow);
  c_event_count: cover property (op == SMT_OP_EVENT && tick);
  c_width_done: cover property (op == SMT_OP_WIDTH && pin_fall);

endmodule // smt_timer

/* smt_far_end.sv */
module smt_far_end (
  // clock and timer pin drive
  input wire logic pclk,
  input wire smt_pkg::smt_pin_drv_s drv,
  // lines seen by the timer
  output logic pin_level,
  output logic scs_level
);
  timeunit 1ns;
  timeprecision 1ns;
  import smt_pkg::*;
  logic ext = 1'b0; // far side pin level
  // timer owns the wire while its enable is low
  assign pin_level = drv.pin_oe_n ? ext : drv.pin_out;
  initial scs_level = 1'b0;
  // set one line, then hold it
  task automatic level(input logic src, input logic v, input int hold);
    @(posedge pclk);
    if (src) begin
      scs_level <= v;
    end else begin
      ext <= v;
    end
    repeat (hold) @(posedge pclk);
  endtask
  // n pulses away from the idle level, fast or slow
  task automatic pulse(input logic src, input logic idle, input int n, input int hold);
    for (int i = 0; i < n; i++) begin
      level(src, !idle, hold);
      level(src, idle, hold);
    end
  endtask
endmodule // smt_far_end

/* tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import smt_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  smt_apb_req_s req = '0;
  smt_apb_rsp_s rsp;
  smt_pin_drv_s drv;
  logic pin_in, scs, timer_irq, pin_irq;
  logic [7:0] q;
  logic e;
  int n_errors = 0;
  int n_tests = 0;
  int n;
  time t0;

  smt_timer #(.PSC_W(6)) smt_timer_i (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .counter_pin_in(pin_in), .counter_pin(drv), .special_count_source(scs), .timer_irq(timer_irq),
    .pin_irq(pin_irq));
  smt_far_end smt_far_end_i (.pclk(pclk), .drv(drv), .pin_level(pin_in), .scs_level(scs));

  // 100 mhz clock
  initial forever #5 pclk = ~pclk;

  task automatic close_out;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      n_errors++;
      $display("FAIL %0t seen %h expected %h", $time, s, x);
    end
  endtask
  // one apb transfer, idle cycle first
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= {24'h0, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    q = rsp.prdata[7:0];
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (k >= 20) begin
      n_errors++;
      close_out();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 8'h00);
  endtask
  // bounded wait for the underflow flag
  task automatic wirq;
    int k;
    k = 0;
    do begin
      @(negedge pclk);
      k++;
    end while (timer_irq !== 1'b1 && k < 2000);
    if (k >= 2000) begin
      n_errors++;
      close_out();
    end
  endtask

  initial begin
    void'($urandom(45727));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(SMT_MODE_ADDR);
    chk(q, SMT_MODE_RST);
    rd(12'h010);
    chk(e, 1'b1);
    // latch only: counter keeps its value until underflow
    wr(SMT_MODE_ADDR, 8'h87);
    wr(SMT_LOW_ADDR, 8'h00);
    wr(SMT_HIGH_ADDR, 8'h01);
    rd(SMT_HIGH_ADDR);
    chk(q, 8'h00);
    wr(SMT_STAT_ADDR, 8'h03);
    wr(SMT_MODE_ADDR, 8'h07);
    wirq();
    rd(SMT_HIGH_ADDR);
    chk(q, 8'h01);
    repeat (80) @(posedge pclk);
    rd(SMT_LOW_ADDR);
    chk(q, 8'h00);
    // write both, halted
    wr(SMT_MODE_ADDR, 8'h80);
    wr(SMT_LOW_ADDR, 8'h34);
    wr(SMT_HIGH_ADDR, 8'h12);
    repeat (40) @(posedge pclk);
    rd(SMT_HIGH_ADDR);
    chk(q, 8'h12);
    rd(SMT_LOW_ADDR);
    chk(q, 8'h34);
    // underflow period per prescaler code
    for (int p = 0; p < 4; p++) begin
      n = $urandom % 4;
      wr(SMT_MODE_ADDR, 8'(8'h80 + 2 * p));
      wr(SMT_LOW_ADDR, 8'(n));
      wr(SMT_HIGH_ADDR, 8'h00);
      wr(SMT_STAT_ADDR, 8'h01);
      wr(SMT_MODE_ADDR, 8'(2 * p));
      wirq();
      t0 = $time;
      wr(SMT_STAT_ADDR, 8'h01);
      wirq();
      chk(32'(($time - t0) / 10), (n + 1) * (8 << p));
    end
    // special source pulses
    wr(SMT_MODE_ADDR, 8'h88);
    wr(SMT_LOW_ADDR, 8'h02);
    wr(SMT_HIGH_ADDR, 8'h00);
    wr(SMT_STAT_ADDR, 8'h03);
    wr(SMT_MODE_ADDR, 8'h08);
    smt_far_end_i.pulse(1'b1, 1'b0, 2, 4);
    chk(timer_irq, 1'b0);
    smt_far_end_i.pulse(1'b1, 1'b0, 1, 4);
    chk(timer_irq, 1'b1);
    // event counting on either edge
    for (int pl = 0; pl < 2; pl++) begin
      wr(SMT_MODE_ADDR, 8'(8'ha0 + 64 * pl));
      smt_far_end_i.level(1'b0, 1'(pl), 8);
      wr(SMT_LOW_ADDR, 8'h02);
      wr(SMT_HIGH_ADDR, 8'h00);
      wr(SMT_STAT_ADDR, 8'h03);
      wr(SMT_MODE_ADDR, 8'(8'h20 + 64 * pl));
      smt_far_end_i.pulse(1'b0, 1'(pl), 2, 3 + 6 * pl);
      chk(timer_irq, 1'b0);
      wr(SMT_STAT_ADDR, 8'h03);
      smt_far_end_i.level(1'b0, !pl, 8);
      chk(timer_irq, 1'b1);
      chk(pin_irq, 1'b0);
      smt_far_end_i.level(1'b0, 1'(pl), 8);
      chk(pin_irq, 1'b1);
    end
    // width measurement of the high period
    wr(SMT_MODE_ADDR, 8'hb0);
    smt_far_end_i.level(1'b0, 1'b0, 8);
    wr(SMT_LOW_ADDR, 8'h02);
    wr(SMT_HIGH_ADDR, 8'h00);
    wr(SMT_STAT_ADDR, 8'h03);
    wr(SMT_MODE_ADDR, 8'h30);
    repeat (100) @(posedge pclk);
    chk(timer_irq, 1'b0);
    smt_far_end_i.level(1'b0, 1'b1, 40);
    chk(timer_irq, 1'b1);
    chk(pin_irq, 1'b0);
    smt_far_end_i.level(1'b0, 1'b0, 8);
    chk(pin_irq, 1'b1);
    // pulse output start level and toggling
    for (int pl = 0; pl < 2; pl++) begin
      wr(SMT_MODE_ADDR, 8'(8'h90 + 64 * pl));
      wr(SMT_LOW_ADDR, 8'h01);
      wr(SMT_HIGH_ADDR, 8'h00);
      chk(drv.pin_oe_n, 1'b0);
      chk(drv.pin_out, !pl);
      wr(SMT_STAT_ADDR, 8'h03);
      wr(SMT_MODE_ADDR, 8'(8'h10 + 64 * pl));
      wirq();
      chk(drv.pin_out, pl);
      wr(SMT_STAT_ADDR, 8'h01);
      wirq();
      chk(drv.pin_out, !pl);
    end
    close_out();
  end
endmodule // tb_top
